// *** hdl/program_flash_access.sv ***
`timescale 1ns/1ps
module program_flash_access
  import flash_access_pkg::*;
#(
  parameter int PROGRAM_CYCLES = PROGRAM_CYCLES_DEFAULT
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic address_low_write,
  input wire logic address_high_write,
  input wire logic data_low_write,
  input wire logic data_high_write,
  input wire logic control_write,
  input wire logic key_write,
  input wire logic [7:0] write_data,
  input wire logic flash_write_protect_cfg,
  output logic [7:0] address_low_byte,
  output logic [7:0] address_high_byte,
  output logic [7:0] data_low_byte,
  output logic [7:0] data_high_byte,
  output logic [7:0] memory_control_reg,
  output logic core_stall,
  output logic busy,
  output logic [ADDR_W-1:0] flash_address,
  output logic flash_read,
  input wire logic [WORD_W-1:0] flash_read_data,
  output logic flash_program,
  output logic [WORD_W-1:0] flash_write_data
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  seq_state_t state;
  key_state_t key_state;
  logic [COUNT_W-1:0] count;
  logic memory_space_select;
  logic program_enable_gate;
  logic protect_sync0;
  logic protect_sync;
  logic read_start;
  logic prog_start;
  logic read_done;
  logic setup_done;
  logic prog_done;
  logic read_busy;
  logic program_busy;

  function automatic logic [COUNT_W-1:0] last_count(input int cycles);
    last_count = COUNT_W'(cycles - 1);
  endfunction

  // true while no read, setup or program phase is running
  function automatic logic is_idle(input seq_state_t s);
    is_idle = s == st_idle;
  endfunction

  // a control byte that asks for a transfer out of program memory
  function automatic logic asks_read(input logic [7:0] b);
    asks_read = b[CTL_READ_TRIG] && b[CTL_MEM_SELECT];
  endfunction

  function automatic logic asks_program(input logic [7:0] b);
    asks_program = b[CTL_PROG_TRIG] && b[CTL_MEM_SELECT];
  endfunction

  function automatic logic [ADDR_W-1:0] word_address(input logic [7:0] high, input logic [7:0] low);
    word_address = {high[ADDR_W-9:0], low};
  endfunction

  function automatic logic [WORD_W-1:0] pack_word(input logic [7:0] high, input logic [7:0] low);
    pack_word = {high[WORD_W-9:0], low};
  endfunction

  // the upper data byte keeps only the six implemented bits
  function automatic logic [7:0] upper_byte(input logic [WORD_W-9:0] bits);
    upper_byte = {2'b00, bits};
  endfunction

  // write protect strap is a pin level, synchronised first
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      protect_sync0 <= 1'b0;
      protect_sync <= 1'b0;
    end else begin
      protect_sync0 <= flash_write_protect_cfg;
      protect_sync <= protect_sync0;
    end
  end

  assign read_start = control_write && asks_read(write_data)
                      && is_idle(state);
  // enable must already be set before this write, and the key armed
  assign prog_start = control_write && asks_program(write_data) && program_enable_gate
                      && key_state == key_armed
                      && protect_sync && is_idle(state) && !read_start;
  assign read_done = state == st_read && count == last_count(READ_STALL_CYCLES);
  assign setup_done = state == st_setup && count == last_count(SETUP_STALL_CYCLES);
  assign prog_done = state == st_program && count == last_count(PROGRAM_CYCLES);

  // ----------------------------------------------------------------
  // control bits
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      memory_space_select <= 1'b0;
      program_enable_gate <= 1'b0;
    end else if (control_write) begin
      memory_space_select <= write_data[CTL_MEM_SELECT];
      program_enable_gate <= write_data[CTL_PROG_ENABLE];
    end
  end

  // ----------------------------------------------------------------
  // unlock key sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      key_state <= key_none;
    end else if (key_write) begin
      if (write_data == KEY_FIRST) begin
        key_state <= key_got_first;
      end else if (write_data == KEY_SECOND && key_state == key_got_first) begin
        key_state <= key_armed;
      end else begin
        key_state <= key_none;
      end
    end else if (control_write || address_low_write || address_high_write
                 || data_low_write || data_high_write) begin
      // any other access breaks the sequence; each word needs a fresh key
      key_state <= key_none;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= st_idle;
    end else begin
      unique case (state)
        st_idle: begin
          if (read_start) begin
            state <= st_read;
          end else if (prog_start) begin
            state <= st_setup;
          end
        end
        st_read: begin
          if (read_done) begin
            state <= st_idle;
          end
        end
        st_setup: begin
          if (setup_done) begin
            state <= st_program;
          end
        end
        st_program: begin
          // timer only; program enable changes are ignored here
          if (prog_done) begin
            state <= st_idle;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // phase counter
  // ----------------------------------------------------------------
  // restarts at every phase boundary so each phase counts from zero
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
    end else if (is_idle(state) || read_done || setup_done || prog_done) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  // core stalls; clock and peripherals are untouched, interrupts queue outside
  assign core_stall = !is_idle(state);
  assign busy = state == st_program;

  // ----------------------------------------------------------------
  // busy flags
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      read_busy <= 1'b0;
    end else if (read_start) begin
      read_busy <= 1'b1;
    end else if (read_done) begin
      read_busy <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      program_busy <= 1'b0;
    end else if (prog_start) begin
      program_busy <= 1'b1;
    end else if (prog_done) begin
      program_busy <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // address and data registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      address_low_byte <= BYTE_RESET;
      address_high_byte <= BYTE_RESET;
    end else begin
      if (address_low_write && state == st_idle) begin
        address_low_byte <= write_data;
      end
      if (address_high_write && state == st_idle) begin
        address_high_byte <= write_data;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      data_low_byte <= BYTE_RESET;
      data_high_byte <= BYTE_RESET;
    end else if (read_done) begin
      data_low_byte <= flash_read_data[7:0];
      data_high_byte <= upper_byte(flash_read_data[WORD_W-1:8]);
    end else if (state == st_idle) begin
      if (data_low_write) begin
        data_low_byte <= write_data;
      end
      if (data_high_write) begin
        data_high_byte <= upper_byte(write_data[WORD_W-9:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // flash array strobes and status
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flash_address <= '0;
      flash_write_data <= '0;
    end else if (is_idle(state)) begin
      flash_address <= word_address(address_high_byte, address_low_byte);
      flash_write_data <= pack_word(data_high_byte, data_low_byte);
    end
  end

  // read strobe drops on the load edge, so it never outlives the stall
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flash_read <= 1'b0;
    end else begin
      flash_read <= read_start || (read_busy && !read_done);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flash_program <= 1'b0;
    end else begin
      flash_program <= setup_done || (state == st_program && !prog_done);
    end
  end

  always_comb begin
    memory_control_reg = 8'h00;
    memory_control_reg[CTL_MEM_SELECT] = memory_space_select;
    memory_control_reg[CTL_PROG_ENABLE] = program_enable_gate;
    memory_control_reg[CTL_READ_TRIG] = read_busy;
    memory_control_reg[CTL_PROG_TRIG] = program_busy;
  end

endmodule

// *** common/flash_access_pkg.sv ***
package flash_access_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int WORD_W = 14;
  localparam int FLASH_DEPTH = 8192;

  // ----------------------------------------------------------------
  // control register bit positions (our own layout)
  // ----------------------------------------------------------------
  localparam int CTL_READ_TRIG = 0;
  localparam int CTL_PROG_TRIG = 1;
  localparam int CTL_PROG_ENABLE = 2;
  localparam int CTL_MEM_SELECT = 7;

  // ----------------------------------------------------------------
  // key values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLOCK_MHZ = 200;
  localparam int CYCLES_PER_INSTR = 4;
  localparam int READ_STALL_INSTR = 2;
  localparam int SETUP_STALL_INSTR = 2;
  localparam int READ_STALL_CYCLES = READ_STALL_INSTR * CYCLES_PER_INSTR;
  localparam int SETUP_STALL_CYCLES = SETUP_STALL_INSTR * CYCLES_PER_INSTR;
  localparam int PROGRAM_TIME_US = 8;
  localparam int PROGRAM_CYCLES_DEFAULT = PROGRAM_TIME_US * CLOCK_MHZ;
  localparam int COUNT_W = 20;

  typedef enum logic [2:0] {
    st_idle,
    st_read,
    st_setup,
    st_program
  } seq_state_t;

  typedef enum logic [1:0] {
    key_none,
    key_got_first,
    key_armed
  } key_state_t;

endpackage

// *** bench/program_flash_access_assertions.sv ***
`timescale 1ns/1ps
module program_flash_access_checker
  import flash_access_pkg::*;
#(
  parameter int PROGRAM_CYCLES = PROGRAM_CYCLES_DEFAULT
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic control_write,
  input wire logic data_low_write,
  input wire logic data_high_write,
  input wire logic [7:0] write_data,
  input wire logic flash_write_protect_cfg,
  input wire logic [7:0] data_low_byte,
  input wire logic [7:0] data_high_byte,
  input wire logic [7:0] memory_control_reg,
  input wire logic core_stall,
  input wire logic busy,
  input wire logic flash_read,
  input wire logic [WORD_W-1:0] flash_read_data,
  input wire logic flash_program
);
  logic [COUNT_W-1:0] prog_cnt;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) prog_cnt <= '0;
    else prog_cnt <= flash_program ? prog_cnt + 1'b1 : '0;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_read_stall;
    control_write && write_data[0] && write_data[7] && !core_stall |=> core_stall [*8] ##1 !core_stall;
  endproperty
  a_read_stall: assert property (p_read_stall) else $error("read stall length wrong");
  property p_read_data;
    $fell(flash_read) |-> {data_high_byte, data_low_byte} == {2'b00, $past(flash_read_data)};
  endproperty
  a_read_data: assert property (p_read_data) else $error("read word not loaded");
  property p_data_hold;
    !core_stall && !data_low_write && !data_high_write |=> $stable({data_high_byte, data_low_byte});
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data bytes changed");
  property p_prog_refused;
    control_write && write_data[1] && !write_data[0] && !memory_control_reg[CTL_PROG_ENABLE] && !core_stall
      |=> !core_stall;
  endproperty
  a_prog_refused: assert property (p_prog_refused) else $error("trigger accepted without enable");
  property p_prog_start;
    $rose(memory_control_reg[CTL_PROG_TRIG]) |-> $past(control_write) && $past(memory_control_reg[CTL_PROG_ENABLE]);
  endproperty
  a_prog_start: assert property (p_prog_start) else $error("program started without cause");
  property p_protect;
    (!flash_write_protect_cfg) [*3] ##0 (control_write && !write_data[0] && !core_stall) |=> !core_stall;
  endproperty
  a_protect: assert property (p_protect) else $error("program while protected");
  property p_prog_len;
    $fell(flash_program) |-> prog_cnt == PROGRAM_CYCLES;
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("program length wrong");
  property p_stall_in_prog;
    flash_program |-> core_stall && busy;
  endproperty
  a_stall_in_prog: assert property (p_stall_in_prog) else $error("core not stalled");
  property p_setup;
    $rose(flash_program) |-> $past(core_stall, 8) && !$past(core_stall, 9);
  endproperty
  a_setup: assert property (p_setup) else $error("setup stall wrong");
  property p_resume;
    $fell(flash_program) |-> ##[0:1] !core_stall;
  endproperty
  a_resume: assert property (p_resume) else $error("core not resumed");
endmodule
bind program_flash_access program_flash_access_checker #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) u_chk (.clock, .reset_n,
  .control_write, .data_low_write, .data_high_write, .write_data, .flash_write_protect_cfg, .data_low_byte,
  .data_high_byte, .memory_control_reg, .core_stall, .busy, .flash_read, .flash_read_data, .flash_program);

// *** bench/flash_array_model.sv ***
`timescale 1ns/1ps
module flash_array_model
  import flash_access_pkg::*;
(
  input wire logic clock,
  input wire logic [ADDR_W-1:0] flash_address,
  input wire logic flash_read,
  output logic [WORD_W-1:0] flash_read_data,
  input wire logic flash_program,
  input wire logic [WORD_W-1:0] flash_write_data
);
  logic [WORD_W-1:0] mem [FLASH_DEPTH];
  initial for (int i = 0; i < FLASH_DEPTH; i++) mem[i] = WORD_W'(i) ^ 14'h1555;
  // inverted outside a read so a late sample is caught
  assign flash_read_data = flash_read ? mem[flash_address] : ~mem[flash_address];
  always @(posedge clock) if (flash_program) mem[flash_address] <= flash_write_data;
endmodule

// *** bench/program_flash_access_tb.sv ***
`timescale 1ns/1ps
module program_flash_access_tb;
  import flash_access_pkg::*;
  logic clock = 0, reset_n = 0, flash_write_protect_cfg = 1;
  logic [5:0] stb = '0;
  logic [7:0] write_data = '0;
  logic address_low_write, address_high_write, data_low_write, data_high_write, control_write, key_write;
  logic [7:0] address_low_byte, address_high_byte, data_low_byte, data_high_byte, memory_control_reg;
  logic core_stall, busy, flash_read, flash_program;
  logic [ADDR_W-1:0] flash_address;
  logic [WORD_W-1:0] flash_read_data, flash_write_data;
  int n_mismatch = 0, tests_run = 0, stall_cnt = 0;
  assign {key_write, control_write, data_high_write, data_low_write, address_high_write, address_low_write} = stb;
  initial forever #2.5 clock = ~clock;
  program_flash_access #(.PROGRAM_CYCLES(10)) dut (.clock, .reset_n, .address_low_write, .address_high_write,
    .data_low_write, .data_high_write, .control_write, .key_write, .write_data, .flash_write_protect_cfg,
    .address_low_byte, .address_high_byte, .data_low_byte, .data_high_byte, .memory_control_reg, .core_stall,
    .busy, .flash_address, .flash_read, .flash_read_data, .flash_program, .flash_write_data);
  flash_array_model array (.clock, .flash_address, .flash_read, .flash_read_data, .flash_program,
    .flash_write_data);
  always @(posedge clock) if (core_stall === 1'b1) stall_cnt++;
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input int w, input logic [7:0] d);
    stb[w] = 1'b1;
    write_data = d;
    @(negedge clock);
    stb = '0;
    @(negedge clock);
  endtask
  task automatic idle();
    for (int i = 0; i < 200 && core_stall !== 1'b0; i++) @(negedge clock);
    if (core_stall !== 1'b0) n_mismatch++;
  endtask
  task automatic trig(input logic [7:0] pre, input logic [7:0] k1, input logic [7:0] k2);
    wr(4, pre);
    wr(5, k1);
    wr(5, k2);
    stall_cnt = 0;
    wr(4, 8'h86);
  endtask
  task automatic print_verdict();
    $display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clock);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    repeat (16) @(negedge clock);
    reset_n = 1'b1;
    @(negedge clock);
    cmp({data_high_byte, data_low_byte}, 16'h0000);
    wr(0, 8'hBC);
    wr(1, 8'h0A);
    cmp({address_high_byte, address_low_byte}, 16'h0ABC);
    stall_cnt = 0;
    wr(4, 8'h81);
    idle();
    cmp(16'(stall_cnt), 16'h0008);
    cmp({data_high_byte, data_low_byte}, {2'b00, 14'h0ABC ^ 14'h1555});
    wr(2, 8'h5A);
    cmp({data_high_byte, data_low_byte}, {2'b00, 6'h0A ^ 6'h15, 8'h5A});
    wr(1, 8'h1F);
    wr(0, 8'h00);
    wr(3, 8'h2A);
    wr(2, 8'h5C);
    trig(8'h80, 8'h55, 8'hAA);
    idle();
    cmp(16'(stall_cnt), 16'h0000);
    trig(8'h84, 8'hAA, 8'h55);
    idle();
    cmp(16'(stall_cnt), 16'h0000);
    flash_write_protect_cfg = 1'b0;
    repeat (3) @(negedge clock);
    trig(8'h84, 8'h55, 8'hAA);
    idle();
    cmp(16'(stall_cnt), 16'h0000);
    flash_write_protect_cfg = 1'b1;
    repeat (3) @(negedge clock);
    trig(8'h84, 8'h55, 8'hAA);
    wr(4, 8'h80);
    repeat (6) @(negedge clock);
    cmp({busy, 7'h00, memory_control_reg}, 16'h8082);
    idle();
    cmp(16'(stall_cnt), 16'h0012);
    stall_cnt = 0;
    wr(4, 8'h81);
    idle();
    cmp({data_high_byte, data_low_byte}, 16'h2A5C);
    print_verdict();
  end
endmodule
